// *** pkg/sssp_pkg.sv ***
// Shared constants, register map and bit helpers for the serial port
package sssp_pkg;
  localparam int WORD_W = 8;
  localparam int FRAME_EDGES = 16;
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [3:0] OVR_BIT_IDX = 4'h6;
  localparam logic [7:0] FAR_MIN_HALF = 8'h08;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_TXBUF = 3'h0;
  localparam logic [2:0] ADDR_RXBUF = 3'h1;
  localparam logic [2:0] ADDR_BRDIV = 3'h2;
  localparam logic [2:0] ADDR_MODE = 3'h3;
  localparam logic [2:0] ADDR_CTL0 = 3'h4;
  localparam logic [2:0] ADDR_CTL1 = 3'h5;
  localparam logic [2:0] ADDR_SMR3 = 3'h6;
  // Field positions
  localparam int MODE_CKSEL = 3;
  localparam int MODE_DINV = 5;
  localparam int MODE_PINV = 7;
  localparam int CTL0_SHIFT_REG_EMPTY_FLAG = 3;
  localparam int CTL0_CLOCK_POLARITY = 6;
  localparam int CTL0_MSBF = 7;
  localparam int CTL1_TE = 0;
  localparam int CTL1_TI = 1;
  localparam int CTL1_RE = 2;
  localparam int CTL1_RI = 3;
  localparam int CTL1_IRS = 4;
  localparam int CTL1_RRM = 5;
  localparam int SMR3_SSE = 0;
  localparam int SMR3_CLOCK_PHASE = 1;
  localparam int SMR3_ROLE = 3;
  localparam int SMR3_FAULT = 7;
  localparam int RXBUF_OVR = 12;
  // Values after reset
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h02;

  // Bit i of a word in the chosen order
  function automatic logic pickBit(input logic [7:0] w, input logic [3:0] i,
                                   input logic msbFirst);
    logic [2:0] k;
    k = i[2:0];
    return msbFirst ? w[3'h7 - k] : w[k];
  endfunction

  // Shift one received bit into a word in the chosen order
  function automatic logic [7:0] shiftIn(input logic [7:0] w, input logic b,
                                         input logic msbFirst);
    return msbFirst ? {w[6:0], b} : {b, w[7:1]};
  endfunction

  // Clock level between frames for a polarity and phase pair
  function automatic logic idleLevel(input logic cpol, input logic clock_phase);
    return ~(cpol ^ clock_phase);
  endfunction
endpackage

// *** pkg/sssp_if.sv ***
// Serial bus wires between the port and the far party
`timescale 1ns/1ps
interface sssp_if;
  logic devClk;
  logic devClkOe;
  logic devA;
  logic devAOe;
  logic devB;
  logic devBOe;
  logic farClk;
  logic farClkOe;
  logic farA;
  logic farAOe;
  logic farSelN;
  logic clkLine;
  logic aLine;
  logic bLine;
  logic selLine;

  // Clock and data wire levels from the enables, pulled high when nobody drives; select follows farSelN
  assign clkLine = devClkOe ? devClk : (farClkOe ? farClk : 1'b1);
  assign aLine = devAOe ? devA : (farAOe ? farA : 1'b1);
  assign bLine = devBOe ? devB : 1'b1;
  assign selLine = farSelN;

  modport dev (output devClk, devClkOe, devA, devAOe, devB, devBOe,
               input clkLine, aLine, bLine, selLine);
  modport far (output farClk, farClkOe, farA, farAOe, farSelN,
               input clkLine, aLine, bLine);
endinterface

// *** hdl/sssp_dev.sv ***
// Serial port with slave-select, the documented device end
`timescale 1ns/1ps
// What this block does
// - each transfer moves exactly one 8-bit word
// - internal clock is source over 2(m+1)
// - external clock comes from clock pin
// - transmit needs enable and loaded buffer
// - receive also needs transmit enable and data
// - transmit irq at load or at completion
// - receive irq when word reaches buffer
// - overrun at seventh bit, no irq
// - master sees select low: float, fault
// - outputs return when fault cleared, select high
// - far master starts only with clock idle
// - polarity chooses shift and sample edges
// - bit order select for both directions
// - buffer read arms next continuous reception
// - data invert and pin invert options
// - slave deselected floats, ignores clock edges
// - master software picks completion transmit irq
// - master with select high drives clock
// - slave phase 0 output undefined until clocking
// - slave phase 1 shows first bit at select
// - both ends share polarity and phase
// - select enable, then role picks master/slave
module sssp_dev (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  output logic txIrq,
  output logic rxIrq,
  sssp_if.dev bus
);
  logic [7:0] txBufQ, rxBufQ, brDivQ, modeQ, ctl0Q, smr3Q;
  logic teQ, tiQ, reQ, riQ, irsQ, rrmQ, ovrQ, faultQ, rrmPendQ;
  logic [2:0] clkS, aS, bS, selS;
  logic [7:0] divCnt, txShQ, rxShQ;
  logic [4:0] edgeCnt;
  logic [3:0] sendCnt, rcvCnt;
  logic sclkQ, doQ, frameOvrQ;
  typedef enum {IDLE, RUN} sssp_state_t;
  sssp_state_t stateQ;

  logic select_pin_enable, master, selHigh, slaveSel, cpol, clock_phase, msbF, dinv, pinv;
  logic tick, edgeEv, newLvl, outEdge, sampEdge, startOk, inBit;
  logic abortM, abortS, rcvDone, frameEnd, busy;

  // Mode decode
  assign select_pin_enable = smr3Q[sssp_pkg::SMR3_SSE];
  assign master = select_pin_enable ? !smr3Q[sssp_pkg::SMR3_ROLE]
                      : !modeQ[sssp_pkg::MODE_CKSEL];
  assign selHigh = selS[1];
  assign slaveSel = !select_pin_enable || !selHigh;
  assign cpol = ctl0Q[sssp_pkg::CTL0_CLOCK_POLARITY];
  assign clock_phase = smr3Q[sssp_pkg::SMR3_CLOCK_PHASE];
  assign msbF = ctl0Q[sssp_pkg::CTL0_MSBF];
  assign dinv = modeQ[sssp_pkg::MODE_DINV];
  assign pinv = modeQ[sssp_pkg::MODE_PINV];
  assign busy = (stateQ == RUN);

  // Pin synchronisers, stage 0 only feeds stage 1
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clkS <= 3'h7;
      aS <= 3'h7;
      bS <= 3'h7;
      selS <= 3'h7;
    end else begin
      clkS <= {clkS[1:0], bus.clkLine};
      aS <= {aS[1:0], bus.aLine};
      bS <= {bS[1:0], bus.bLine};
      selS <= {selS[1:0], bus.selLine};
    end
  end

  // Edge sources: own divider as master, pin as slave
  assign tick = master && busy && (divCnt == brDivQ);
  assign edgeEv = master ? tick
                         : (slaveSel && (clkS[1] ^ clkS[2]));
  assign newLvl = master ? !sclkQ : clkS[1];
  assign outEdge = busy && edgeEv && (newLvl == cpol);
  assign sampEdge = busy && edgeEv && (newLvl != cpol);
  assign inBit = (master ? bS[1] : aS[1]) ^ pinv ^ dinv;

  // Start, abort and completion conditions
  assign startOk = !busy && teQ && (!tiQ || rrmPendQ)
    && (master ? (!select_pin_enable || selHigh) && !faultQ
               : slaveSel && (clkS[1] == sssp_pkg::idleLevel(cpol, clock_phase)));
  assign abortM = master && select_pin_enable && !selHigh;
  assign abortS = !master && busy && !slaveSel;
  assign rcvDone = sampEdge && (rcvCnt == sssp_pkg::FRAME_BITS - 4'h1);
  assign frameEnd = master
    ? (tick && (edgeCnt == 5'(sssp_pkg::FRAME_EDGES - 1)))
    : rcvDone;

  // Bit rate divider and own clock level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt <= 8'h00;
      sclkQ <= 1'b1;
      edgeCnt <= 5'h00;
    end else if (!busy) begin
      divCnt <= 8'h00;
      sclkQ <= sssp_pkg::idleLevel(cpol, clock_phase);
      edgeCnt <= 5'h00;
    end else if (tick) begin
      divCnt <= 8'h00;
      sclkQ <= !sclkQ;
      edgeCnt <= edgeCnt + 5'h01;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // Frame sequencer and shift registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= IDLE;
      txShQ <= 8'h00;
      rxShQ <= 8'h00;
      sendCnt <= 4'h0;
      rcvCnt <= 4'h0;
      doQ <= 1'b1;
    end else begin
      case (stateQ)
        IDLE: begin
          if (startOk) begin
            stateQ <= RUN;
            txShQ <= rrmPendQ && tiQ ? txShQ : txBufQ;
            rcvCnt <= 4'h0;
            if (clock_phase) begin
              doQ <= sssp_pkg::pickBit(txBufQ, 4'h0, msbF) ^ dinv ^ pinv;
              sendCnt <= 4'h1;
            end else begin
              sendCnt <= 4'h0;
            end
          end
        end
        RUN: begin
          if (abortS || (master && abortM) || frameEnd) begin
            stateQ <= IDLE;
          end
          if (outEdge && sendCnt < sssp_pkg::FRAME_BITS) begin
            doQ <= sssp_pkg::pickBit(txShQ, sendCnt, msbF) ^ dinv ^ pinv;
            sendCnt <= sendCnt + 4'h1;
          end
          if (sampEdge && rcvCnt < sssp_pkg::FRAME_BITS) begin
            rxShQ <= sssp_pkg::shiftIn(rxShQ, inBit, msbF);
            rcvCnt <= rcvCnt + 4'h1;
          end
        end
        default: stateQ <= IDLE;
      endcase
    end
  end

  // Register writes and hardware-set flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txBufQ <= sssp_pkg::BYTE_RST;
      rxBufQ <= sssp_pkg::BYTE_RST;
      brDivQ <= sssp_pkg::BYTE_RST;
      modeQ <= sssp_pkg::BYTE_RST;
      ctl0Q <= sssp_pkg::BYTE_RST;
      smr3Q <= sssp_pkg::BYTE_RST;
      {rrmQ, irsQ, riQ, reQ, tiQ, teQ} <= sssp_pkg::CTL1_RST[5:0];
      ovrQ <= 1'b0;
      faultQ <= 1'b0;
      rrmPendQ <= 1'b0;
      frameOvrQ <= 1'b0;
    end else begin
      if (regWr) begin
        case (regAddr)
          sssp_pkg::ADDR_BRDIV: brDivQ <= regWdata[7:0];
          sssp_pkg::ADDR_MODE: modeQ <= regWdata[7:0];
          sssp_pkg::ADDR_CTL0: ctl0Q <= regWdata[7:0];
          sssp_pkg::ADDR_SMR3: smr3Q <= regWdata[7:0];
          sssp_pkg::ADDR_CTL1: begin
            teQ <= regWdata[sssp_pkg::CTL1_TE];
            reQ <= regWdata[sssp_pkg::CTL1_RE];
            irsQ <= regWdata[sssp_pkg::CTL1_IRS];
            rrmQ <= regWdata[sssp_pkg::CTL1_RRM];
          end
          default: ;
        endcase
      end
      // Transmit buffer empty: load at start, a same-cycle write refills
      if (startOk) begin
        tiQ <= 1'b1;
      end
      if (regWr && regAddr == sssp_pkg::ADDR_TXBUF) begin
        txBufQ <= regWdata[7:0];
        tiQ <= 1'b0;
      end
      // Continuous receive: a read arms one reception, mode off drops it
      if (startOk || !rrmQ) begin
        rrmPendQ <= 1'b0;
      end else if (regRd && regAddr == sssp_pkg::ADDR_RXBUF && rrmQ) begin
        rrmPendQ <= 1'b1;
      end
      // Receive complete and overrun, set wins over clear
      if (regRd && regAddr == sssp_pkg::ADDR_RXBUF) begin
        riQ <= 1'b0;
      end
      if (regWr && regAddr == sssp_pkg::ADDR_CTL1
          && !regWdata[sssp_pkg::CTL1_RE]) begin
        ovrQ <= 1'b0;
      end
      if (startOk) begin
        frameOvrQ <= 1'b0;
      end
      if (sampEdge && rcvCnt == sssp_pkg::OVR_BIT_IDX && riQ && reQ) begin
        ovrQ <= 1'b1;
        frameOvrQ <= 1'b1;
      end
      if (rcvDone && reQ) begin
        rxBufQ <= sssp_pkg::shiftIn(rxShQ, inBit, msbF);
        if (!frameOvrQ) begin
          riQ <= 1'b1;
        end
      end
      // Fault: cleared only while select is high, a new fault wins
      if (regWr && regAddr == sssp_pkg::ADDR_SMR3
          && !regWdata[sssp_pkg::SMR3_FAULT] && selHigh) begin
        faultQ <= 1'b0;
      end
      if (abortM) begin
        faultQ <= 1'b1;
      end
    end
  end

  // Interrupt pulses
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
    end else begin
      txIrq <= (!irsQ && startOk) || (irsQ && busy && frameEnd);
      rxIrq <= rcvDone && reQ && !frameOvrQ;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        sssp_pkg::ADDR_RXBUF: begin
          regRdata <= 16'h0000;
          regRdata[7:0] <= rxBufQ;
          regRdata[sssp_pkg::RXBUF_OVR] <= ovrQ;
        end
        sssp_pkg::ADDR_BRDIV: regRdata <= {8'h00, brDivQ};
        sssp_pkg::ADDR_MODE: regRdata <= {8'h00, modeQ};
        sssp_pkg::ADDR_CTL0: begin
          regRdata <= {8'h00, ctl0Q};
          regRdata[sssp_pkg::CTL0_SHIFT_REG_EMPTY_FLAG] <= !busy;
        end
        sssp_pkg::ADDR_CTL1: regRdata <= {10'h000, rrmQ, irsQ, riQ, reQ,
                                          tiQ, teQ};
        sssp_pkg::ADDR_SMR3: begin
          regRdata <= {8'h00, smr3Q};
          regRdata[sssp_pkg::SMR3_FAULT] <= faultQ;
        end
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus.devClk <= 1'b1;
      bus.devClkOe <= 1'b0;
      bus.devA <= 1'b1;
      bus.devAOe <= 1'b0;
      bus.devB <= 1'b1;
      bus.devBOe <= 1'b0;
    end else begin
      bus.devClk <= sclkQ;
      bus.devClkOe <= master && !faultQ && !abortM;
      bus.devA <= doQ;
      bus.devAOe <= master && !faultQ && !abortM;
      bus.devB <= doQ;
      bus.devBOe <= !master && slaveSel;
    end
  end
endmodule // sssp_dev

// *** hdl/sssp_far.sv ***
// Far-end master that selects the port and clocks one word
`timescale 1ns/1ps
module sssp_far #(
  parameter int HALF_W = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [7:0] txData,
  input wire logic cpol,
  input wire logic clock_phase,
  input wire logic msbFirst,
  input wire logic [HALF_W-1:0] halfPeriod,
  output logic busy,
  output logic done,
  output logic [7:0] rxData,
  sssp_if.far bus
);
  typedef enum {F_IDLE, F_SETUP, F_RUN, F_HOLD} sssp_far_state_t;
  sssp_far_state_t stateQ;
  logic [HALF_W-1:0] cnt;
  logic [4:0] edgeCnt;
  logic [3:0] sendCnt;
  logic [7:0] txShQ, rxShQ;
  logic clkQ;
  logic halfDone;

  // Refuse a counter too narrow for the minimum half period
  if (HALF_W < 4) begin : gHalfCheck
    $error("HALF_W too small for the minimum half period");
  end

  assign halfDone = (cnt == halfPeriod);

  // Select, clock and data sequencing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= F_IDLE;
      cnt <= '0;
      edgeCnt <= 5'h00;
      sendCnt <= 4'h0;
      txShQ <= 8'h00;
      rxShQ <= 8'h00;
      clkQ <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      rxData <= 8'h00;
      bus.farClk <= 1'b1;
      bus.farClkOe <= 1'b0;
      bus.farA <= 1'b1;
      bus.farAOe <= 1'b0;
      bus.farSelN <= 1'b1;
    end else begin
      done <= 1'b0;
      bus.farClk <= clkQ;
      case (stateQ)
        F_IDLE: begin
          if (start) begin
            stateQ <= F_SETUP;
            busy <= 1'b1;
            cnt <= '0;
            edgeCnt <= 5'h00;
            txShQ <= txData;
            clkQ <= sssp_pkg::idleLevel(cpol, clock_phase);
            bus.farClk <= sssp_pkg::idleLevel(cpol, clock_phase);
            bus.farClkOe <= 1'b1;
            bus.farAOe <= 1'b1;
            bus.farSelN <= 1'b0;
            if (clock_phase) begin
              bus.farA <= sssp_pkg::pickBit(txData, 4'h0, msbFirst);
              sendCnt <= 4'h1;
            end else begin
              sendCnt <= 4'h0;
            end
          end
        end
        F_SETUP: begin
          cnt <= halfDone ? '0 : cnt + 1'b1;
          if (halfDone) begin
            stateQ <= F_RUN;
          end
        end
        F_RUN: begin
          cnt <= halfDone ? '0 : cnt + 1'b1;
          if (halfDone) begin
            clkQ <= !clkQ;
            edgeCnt <= edgeCnt + 5'h01;
            if (!clkQ == cpol && sendCnt < sssp_pkg::FRAME_BITS) begin
              bus.farA <= sssp_pkg::pickBit(txShQ, sendCnt, msbFirst);
              sendCnt <= sendCnt + 4'h1;
            end
            if (!clkQ != cpol) begin
              rxShQ <= sssp_pkg::shiftIn(rxShQ, bus.bLine, msbFirst);
            end
            if (edgeCnt == 5'(sssp_pkg::FRAME_EDGES - 1)) begin
              stateQ <= F_HOLD;
            end
          end
        end
        F_HOLD: begin
          cnt <= halfDone ? '0 : cnt + 1'b1;
          if (halfDone) begin
            stateQ <= F_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            rxData <= rxShQ;
            bus.farClkOe <= 1'b0;
            bus.farAOe <= 1'b0;
            bus.farSelN <= 1'b1;
          end
        end
        default: stateQ <= F_IDLE;
      endcase
    end
  end
endmodule // sssp_far

// *** verif/sssp_properties.sv ***
// Wire-level properties of the serial port and its far master
`timescale 1ns/1ps
module sssp_properties (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic devClk,
  input wire logic devClkOe,
  input wire logic devAOe,
  input wire logic devBOe,
  input wire logic farClkOe,
  input wire logic farSelN,
  input wire logic clkLine,
  input wire logic selLine
);
  logic prevClk_q;
  logic prevFarOe_q;
  logic prevDevClk_q;
  logic prevDevOe_q;
  logic [4:0] farEdges_q;
  logic [4:0] burst_q;
  logic [8:0] quiet_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Previous levels for edge detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prevClk_q <= 1'h1;
      prevFarOe_q <= 1'h0;
      prevDevClk_q <= 1'h1;
      prevDevOe_q <= 1'h0;
    end else begin
      prevClk_q <= clkLine;
      prevFarOe_q <= farClkOe;
      prevDevClk_q <= devClk;
      prevDevOe_q <= devClkOe;
    end
  end

  // Clock edges made by the far master within one selection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      farEdges_q <= 5'h00;
    end else if (farSelN) begin
      farEdges_q <= 5'h00;
    end else if (farClkOe && prevFarOe_q && clkLine != prevClk_q) begin
      farEdges_q <= farEdges_q + 5'h01;
    end
  end

  // Device clock edges per burst; a long quiet closes the burst
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      quiet_q <= 9'h000;
      burst_q <= 5'h00;
    end else if (devClkOe && prevDevOe_q && devClk != prevDevClk_q) begin
      quiet_q <= 9'h000;
      burst_q <= burst_q + 5'h01;
    end else if (quiet_q == 9'h12B) begin
      quiet_q <= 9'h000;
      burst_q <= 5'h00;
    end else begin
      quiet_q <= quiet_q + 9'h001;
    end
  end

  sequence deselected;
    selLine [*8];
  endsequence

  sequence clkSetup;
    $stable(clkLine) [*5];
  endsequence

  a_slave_float: assert property (deselected |-> !devBOe)
    else $error("slave data driven while deselected");
  a_fault_float: assert property ($fell(selLine) && devClkOe |->
    ##[1:8] (!devClkOe && !devAOe))
    else $error("master pins not floated on select low");
  a_reenable_high: assert property ($rose(devClkOe) |->
    selLine && $past(selLine, 2))
    else $error("clock output enabled with select low");
  a_float_holds: assert property (!devClkOe && !selLine |=> !devClkOe)
    else $error("clock output returned while select low");
  a_far_setup: assert property ($fell(farSelN) |-> ##2 clkSetup)
    else $error("far clock moved during setup");
  a_far_clock: assert property ($fell(farSelN) |-> ##[0:2] farClkOe)
    else $error("far master did not drive the clock");
  a_far_edges: assert property ($rose(farSelN) |-> farEdges_q == 5'h10)
    else $error("far frame edge count not sixteen");
  a_dev_burst: assert property (quiet_q == 9'h12B |->
    (burst_q == 5'h00 || burst_q == 5'h10))
    else $error("device clock burst not sixteen edges");
endmodule // sssp_properties

// *** verif/test_slave_select_serial_port.sv ***
// Self-checking bench joining the port and a far master
`timescale 1ns/1ps
module test_slave_select_serial_port;
  typedef struct packed {
    logic cpol;
    logic clock_phase;
    logic msb;
    logic [1:0] inv;
    logic [7:0] farByte;
    logic [7:0] devByte;
  } sssp_row_t;
  logic mclk;
  logic arst_n;
  logic [2:0] regAddr;
  logic [15:0] regWdata;
  logic regWr;
  logic regRd;
  logic [15:0] regRdata;
  logic txIrq;
  logic rxIrq;
  logic farStart;
  logic [7:0] farTx;
  logic farCpol;
  logic farCkph;
  logic farMsb;
  logic farDone;
  logic [7:0] farRx;
  logic [15:0] rd;
  logic flip;
  int nErrors;
  int compares;
  int nTx;
  int nRx;
  int txBase;
  int rxBase;
  sssp_row_t rows [5];

  sssp_if link ();
  sssp_dev sssp_dev_inst (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .txIrq(txIrq), .rxIrq(rxIrq), .bus(link.dev));
  sssp_far sssp_far_inst (.mclk(mclk), .arst_n(arst_n), .start(farStart),
    .txData(farTx), .cpol(farCpol), .clock_phase(farCkph), .msbFirst(farMsb),
    .halfPeriod(sssp_pkg::FAR_MIN_HALF), .busy(), .done(farDone),
    .rxData(farRx),
    .bus(link.far));
  sssp_properties sssp_properties_inst (.mclk(mclk), .arst_n(arst_n),
    .devClk(link.devClk), .devClkOe(link.devClkOe), .devAOe(link.devAOe),
    .devBOe(link.devBOe), .farClkOe(link.farClkOe),
    .farSelN(link.farSelN), .clkLine(link.clkLine), .selLine(link.selLine));

  // Clock
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  // Interrupt pulse counters
  always @(posedge mclk) begin
    if (txIrq === 1'h1) nTx++;
    if (rxIrq === 1'h1) nRx++;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask

  task automatic rdReg(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'h0;
    #1 d = regRdata;
  endtask

  task automatic farGo(input logic [7:0] b);
    @(posedge mclk);
    farTx <= b;
    farStart <= 1'h1;
    @(posedge mclk);
    farStart <= 1'h0;
  endtask

  task automatic farWait();
    for (int i = 0; i < 600 && farDone !== 1'h1; i++) @(negedge mclk);
    chk("far done", 16'h0001, {15'h0000, farDone});
  endtask

  task automatic cfgSlave(input sssp_row_t r, input logic [7:0] ctl1);
    wr(sssp_pkg::ADDR_SMR3, {12'h000, 1'h1, 1'h0, r.clock_phase, 1'h1});
    wr(sssp_pkg::ADDR_MODE, {8'h00, r.inv[1], 1'h0, r.inv[0], 5'h08});
    wr(sssp_pkg::ADDR_CTL0, {8'h00, r.msb, r.cpol, 6'h00});
    wr(sssp_pkg::ADDR_CTL1, {8'h00, ctl1});
    farCpol <= r.cpol;
    farCkph <= r.clock_phase;
    farMsb <= r.msb;
    repeat (10) @(posedge mclk);
  endtask

  task automatic watchMaster(input logic [15:0] expEdges,
                             input logic [7:0] expByte);
    logic prev;
    logic [7:0] got;
    int edges;
    int gap;
    prev = link.clkLine;
    got = 8'h00;
    edges = 0;
    gap = 0;
    for (int i = 0; i < 200; i++) begin
      @(negedge mclk);
      gap++;
      if (link.clkLine !== prev) begin
        if (edges > 0) chk("half period", 16'h0003, 16'(gap));
        if (link.clkLine === 1'h1) got = {got[6:0], link.aLine};
        edges++;
        gap = 0;
        prev = link.clkLine;
      end
    end
    chk("clock edges", expEdges, 16'(edges));
    if (expEdges != 0) chk("data out", {8'h00, expByte}, {8'h00, got});
  endtask

  task automatic giveVerdict();
    $display("compares %0d mismatches %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    giveVerdict();
  end

  // Main sequence
  initial begin
    arst_n = 1'h0;
    regAddr = 3'h0;
    regWdata = 16'h0000;
    regWr = 1'h0;
    regRd = 1'h0;
    farStart = 1'h0;
    farTx = 8'h00;
    farCpol = 1'h0;
    farCkph = 1'h0;
    farMsb = 1'h0;
    nErrors = 0;
    compares = 0;
    nTx = 0;
    nRx = 0;
    rows = '{'{1'h0, 1'h0, 1'h0, 2'h0, 8'h5A, 8'hC3},
             '{1'h1, 1'h0, 1'h1, 2'h0, 8'h81, 8'h7E},
             '{1'h0, 1'h1, 1'h1, 2'h1, 8'h3C, 8'hA5},
             '{1'h1, 1'h1, 1'h0, 2'h2, 8'h01, 8'h80},
             '{1'h0, 1'h1, 1'h0, 2'h3, 8'h96, 8'h69}};
    repeat (3) @(posedge mclk);
    arst_n <= 1'h1;
    for (int a = 0; a < 8; a++) begin
      rdReg(3'(a), rd);
      chk("reset value", (a == 5) ? {8'h00, sssp_pkg::CTL1_RST} :
          (a == 4) ? 16'(16'h0001 << sssp_pkg::CTL0_SHIFT_REG_EMPTY_FLAG) :
          {8'h00, sssp_pkg::BYTE_RST}, rd);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      cfgSlave(rows[i], 8'h05);
      chk("slave out enable", 16'h0000, {15'h0000, link.devBOe});
      txBase = nTx;
      rxBase = nRx;
      flip = rows[i].inv[0] ^ rows[i].inv[1];
      wr(sssp_pkg::ADDR_TXBUF, {8'h00, rows[i].devByte});
      farGo(rows[i].farByte);
      farWait();
      rdReg(sssp_pkg::ADDR_RXBUF, rd);
      chk("slave rx", {8'h00, rows[i].farByte ^ {8{flip}}}, rd);
      chk("far rx", {8'h00, rows[i].devByte ^ {8{flip}}}, {8'h00, farRx});
      chk("irq counts", 16'h0101, {8'(nTx - txBase), 8'(nRx - rxBase)});
    end
    $display("mode table test done");
    cfgSlave(rows[0], 8'h05);
    rxBase = nRx;
    repeat (2) begin
      wr(sssp_pkg::ADDR_TXBUF, 16'h0011);
      farGo(8'h22);
      farWait();
    end
    rdReg(sssp_pkg::ADDR_RXBUF, rd);
    chk("overrun flag", 16'h0001, {15'h0000, rd[sssp_pkg::RXBUF_OVR]});
    chk("rx irq count", 16'h0001, 16'(nRx - rxBase));
    wr(sssp_pkg::ADDR_CTL1, 16'h0001);
    $display("overrun test done");
    cfgSlave(rows[0], 8'h25);
    wr(sssp_pkg::ADDR_TXBUF, 16'h0044);
    farGo(8'h5A);
    farWait();
    rdReg(sssp_pkg::ADDR_RXBUF, rd);
    farGo(8'hA5);
    farWait();
    rdReg(sssp_pkg::ADDR_RXBUF, rd);
    chk("continuous rx", 16'h00A5, rd);
    $display("continuous test done");
    wr(sssp_pkg::ADDR_CTL0, 16'h0000);
    wr(sssp_pkg::ADDR_MODE, 16'h0000);
    wr(sssp_pkg::ADDR_CTL1, 16'h0015);
    wr(sssp_pkg::ADDR_SMR3, 16'h0001);
    repeat (5) @(posedge mclk);
    chk("master clock drive", 16'h0001, {15'h0000, link.devClkOe});
    farGo(8'h33);
    repeat (12) @(posedge mclk);
    #1 chk("float pins", 16'h0000, {14'h0000, link.devClkOe, link.devAOe});
    wr(sssp_pkg::ADDR_SMR3, 16'h0001);
    rdReg(sssp_pkg::ADDR_SMR3, rd);
    chk("fault kept", 16'h0081, rd);
    farWait();
    repeat (3) @(posedge mclk); // Select synchroniser latency
    wr(sssp_pkg::ADDR_SMR3, 16'h0001);
    repeat (5) @(posedge mclk);
    rdReg(sssp_pkg::ADDR_SMR3, rd);
    chk("fault cleared", 16'h0001, rd);
    chk("clock restored", 16'h0001, {15'h0000, link.devClkOe});
    $display("fault test done");
    wr(sssp_pkg::ADDR_BRDIV, 16'h0002);
    wr(sssp_pkg::ADDR_CTL0, 16'h0080);
    txBase = nTx;
    wr(sssp_pkg::ADDR_TXBUF, 16'h00A5);
    watchMaster(16'h0010, 8'hA5);
    rdReg(sssp_pkg::ADDR_RXBUF, rd);
    chk("master rx", 16'h00FF, rd);
    chk("tx irq at end", 16'h0001, 16'(nTx - txBase));
    wr(sssp_pkg::ADDR_CTL1, 16'h0000);
    wr(sssp_pkg::ADDR_TXBUF, 16'h003C);
    watchMaster(16'h0000, 8'h00);
    wr(sssp_pkg::ADDR_CTL1, 16'h0015);
    watchMaster(16'h0010, 8'h3C);
    repeat (320) @(posedge mclk);
    $display("master test done");
    // Second reset in mid-run
    arst_n <= 1'h0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'h1;
    rdReg(sssp_pkg::ADDR_CTL1, rd);
    chk("reset again", {8'h00, sssp_pkg::CTL1_RST}, rd);
    rdReg(sssp_pkg::ADDR_SMR3, rd);
    chk("reset again", {8'h00, sssp_pkg::BYTE_RST}, rd);
    $display("second reset test done");
    giveVerdict();
  end
endmodule // test_slave_select_serial_port
